// file: sbt_pkg.sv
/*
 * Constants and the state record of the sixteen-bit timer block.
 * Assumes a single 40 MHz system clock and byte-wide registers, one per
 * aligned 32-bit word on the register bus.
 */
`default_nettype none

package sbt_pkg;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CNT_LO = 5'h04;
    localparam logic [4:0] OFS_CNT_HI = 5'h08;
    localparam logic [4:0] OFS_CMP_LO = 5'h0C;
    localparam logic [4:0] OFS_CMP_HI = 5'h10;
    localparam logic [4:0] OFS_CMODE = 5'h14;
    localparam logic [4:0] OFS_FLAG = 5'h18;
    localparam logic [4:0] OFS_IE = 5'h1C;

    // control field positions
    localparam int CTRL_ON = 0;
    localparam int CTRL_CS = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_OSC = 3;
    localparam int CTRL_PS = 4;
    localparam int CTRL_W = 6;

    // reset values and codes
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [3:0] CMODE_RST = 4'h0;
    localparam logic [3:0] CMODE_TRIG = 4'hB;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [1:0] QDIV_LAST = 2'h3;   // system clock divided by four

    // whole state of the timer block
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [15:0] cnt;
        logic [15:0] cmp;
        logic [3:0] cmode;
        logic ovf_flag;
        logic ovf_ie;
        logic [2:0] psc;
        logic [1:0] qdiv;
        logic src_q;
        logic armed;
        logic sync1;
        logic sync2;
        logic ack;
        logic [31:0] rdata;
    } sbt_state_t;

endpackage : sbt_pkg

`default_nettype wire

// file: sbt_timer.sv
/*
 * Sixteen-bit timer/counter with prescaler, external or oscillator clock
 * source, compare-driven period clear and an Avalon-MM register slave.
 * Assumes rst is the power-on / brown-out reset; other resets arrive on
 * other_rst. Pin inputs are synchronous to sys_clk.
 */
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module sbt_timer
    import sbt_pkg::*;
(
    input wire logic sys_clk,             // system clock, 40 MHz
    input wire logic rst,                 // power-on / brown-out reset
    input wire logic other_rst,           // any other device reset
    input wire logic [4:0] address,       // byte address
    input wire logic [3:0] byteenable,    // byte lanes
    input wire logic read,                // read request
    input wire logic write,               // write request
    input wire logic [31:0] writedata,    // write data
    output logic [31:0] readdata,         // read data
    output logic waitrequest,             // stall
    input wire logic ext_clk_pin,         // external clock input
    input wire logic osc_input_pin,       // crystal oscillator input
    output logic osc_output_pin,          // oscillator amplifier output
    output logic osc_output_pin_oe,       // oscillator output drive enable
    input wire logic adc_enabled,         // converter is enabled
    output logic adc_start,               // conversion start pulse
    output logic overflow_irq             // overflow interrupt request
);

    sbt_state_t s_q;
    sbt_state_t s_d;

    logic on_w;
    logic cs_w;
    logic async_w;
    logic src_w;
    logic raw_tick;
    logic ptick;
    logic inc;
    logic trig;
    logic acc;
    logic cnt_wr;
    logic [2:0] psc_lim;

    // true when the bus offset hits a given register; byte lanes are not checked here
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        return a == ofs;
    endfunction : hit

    assign on_w = s_q.ctrl[CTRL_ON];
    assign cs_w = s_q.ctrl[CTRL_CS];
    assign async_w = cs_w & s_q.ctrl[CTRL_SYNC];

    // oscillator inverter drives out only while enabled
    assign osc_output_pin_oe = s_q.ctrl[CTRL_OSC];
    assign osc_output_pin = s_q.ctrl[CTRL_OSC] & ~osc_input_pin;
    // oscillator pin replaces the plain pin when enabled
    assign src_w = s_q.ctrl[CTRL_OSC] ? osc_input_pin : ext_clk_pin;

    // quarter-rate tick or armed rising pin edge
    assign raw_tick = cs_w ? (src_w & ~s_q.src_q & s_q.armed) : (s_q.qdiv == QDIV_LAST);

    assign psc_lim = 3'((4'h1 << s_q.ctrl[CTRL_PS +: 2]) - 4'h1);
    assign ptick = on_w & raw_tick & (s_q.psc == psc_lim);

    // synchronized counting sits two stages behind the prescaler
    assign inc = on_w & ((cs_w & ~s_q.ctrl[CTRL_SYNC]) ? s_q.sync2 : ptick);

    // clear on the increment after reaching the compare value
    assign trig = (s_q.cmode == CMODE_TRIG) & ~async_w & inc & (s_q.cnt == s_q.cmp);
    assign adc_start = trig & adc_enabled;

    // bus answers on the second cycle of a request
    assign acc = (read | write) & s_q.ack;
    assign waitrequest = (read | write) & ~s_q.ack;
    assign readdata = s_q.rdata;
    assign cnt_wr = acc & write & byteenable[0]
        & (hit(address, OFS_CNT_LO) | hit(address, OFS_CNT_HI));

    assign overflow_irq = s_q.ovf_flag & s_q.ovf_ie;

    // next state
    always_comb begin
        s_d = s_q;
        s_d.src_q = src_w;
        s_d.qdiv = s_q.qdiv + 2'h1;
        s_d.ack = (read | write) & ~s_q.ack;
        s_d.sync1 = ptick;
        s_d.sync2 = s_q.sync1;

        // a pin count starts only after a falling edge is seen once enabled
        if (!on_w || !cs_w) begin
            s_d.armed = 1'b0;
        end else if (!src_w && s_q.src_q) begin
            s_d.armed = 1'b1;
        end

        if (on_w && raw_tick) begin
            s_d.psc = ptick ? 3'h0 : s_q.psc + 3'h1;
        end

        // write beats trigger, trigger beats increment; a byte write freezes the other byte
        if (trig && !cnt_wr) begin
            s_d.cnt = 16'h0000;
        end else if (inc && !cnt_wr) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end

        // register reads are latched in the stall cycle so data is from a flop
        if (read && !s_q.ack) begin
            s_d.rdata = 32'h0000_0000;
            case (address)
                OFS_CTRL: s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
                // count is a plain flop, stable while read
                OFS_CNT_LO: s_d.rdata[7:0] = s_q.cnt[7:0];
                OFS_CNT_HI: s_d.rdata[7:0] = s_q.cnt[15:8];
                OFS_CMP_LO: s_d.rdata[7:0] = s_q.cmp[7:0];
                OFS_CMP_HI: s_d.rdata[7:0] = s_q.cmp[15:8];
                OFS_CMODE: s_d.rdata[3:0] = s_q.cmode;
                OFS_FLAG: s_d.rdata[0] = s_q.ovf_flag;
                OFS_IE: s_d.rdata[0] = s_q.ovf_ie;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // register writes take effect on the answer edge
        if (acc && write && byteenable[0]) begin
            case (address)
                // plain store: 0Fh sets the ON, CS, SYNC and OSC bits at once and leaves PS at 0
                OFS_CTRL: s_d.ctrl = writedata[CTRL_W-1:0];
                // write wins over increment and trigger clear
                OFS_CNT_LO: s_d.cnt[7:0] = writedata[7:0];
                OFS_CNT_HI: s_d.cnt[15:8] = writedata[7:0];
                OFS_CMP_LO: s_d.cmp[7:0] = writedata[7:0];
                OFS_CMP_HI: s_d.cmp[15:8] = writedata[7:0];
                OFS_CMODE: s_d.cmode = writedata[3:0];
                OFS_FLAG: s_d.ovf_flag = writedata[0];
                OFS_IE: s_d.ovf_ie = writedata[0];
                default: s_d.ctrl = s_d.ctrl;
            endcase
        end

        // counter byte writes restart the prescaler
        if (cnt_wr) begin
            s_d.psc = 3'h0;
            s_d.sync1 = 1'b0;
            s_d.sync2 = 1'b0;
        end

        // rollover sets the flag; a set beats a bus clear in the same cycle
        if (inc && !trig && !cnt_wr && s_q.cnt == CNT_MAX) begin
            s_d.ovf_flag = 1'b1;
        end

        // other resets leave control and count alone
        if (other_rst) begin
            s_d.ovf_flag = 1'b0;
            s_d.ovf_ie = 1'b0;
            s_d.cmode = CMODE_RST;
            s_d.psc = 3'h0;
            s_d.ack = 1'b0;
        end

        // power-on zeroes control but keeps the count
        if (rst) begin
            s_d = '0;
            s_d.ctrl = CTRL_RST;
            s_d.cmp = CMP_RST;
            s_d.cmode = CMODE_RST;
            s_d.cnt = s_q.cnt;
        end
    end

    // single state register, reset handled above
    always_ff @(posedge sys_clk) begin
        s_q <= s_d;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence sync_path_s;
        ptick && on_w && cs_w && !s_q.ctrl[CTRL_SYNC] && !cnt_wr;
    endsequence

    sequence two_stage_s;
        ##1 !cnt_wr ##1 (on_w && cs_w && !s_q.ctrl[CTRL_SYNC]);
    endsequence

    ctrl_por_a: assert property (disable iff (1'b0) rst |=> s_q.ctrl == CTRL_RST)
        else $error("control not cleared by power-on reset");

    // checked on a reset that lands on a configured block, where the count is settled
    cnt_keep_a: assert property (disable iff (1'b0)
        rst && s_q.ctrl != CTRL_RST |=> s_q.cnt == $past(s_q.cnt))
        else $error("reset changed the count");

    trig_clear_a: assert property (trig && !cnt_wr |=> s_q.cnt == 16'h0000)
        else $error("trigger did not clear the count");

    trig_async_a: assert property (async_w |-> !trig && !adc_start)
        else $error("trigger honoured in async mode");

    write_wins_a: assert property (acc && write && byteenable[0] && trig
        && hit(address, OFS_CNT_LO) |=> s_q.cnt[7:0] == $past(writedata[7:0])
        && s_q.cnt[15:8] == $past(s_q.cnt[15:8]))
        else $error("trigger beat a counter write");

    psc_clear_a: assert property (cnt_wr |=> s_q.psc == 3'h0 && !s_q.sync2)
        else $error("prescaler not cleared by counter write");

    ovf_set_a: assert property (inc && !trig && !cnt_wr && s_q.cnt == CNT_MAX
        |=> s_q.cnt == 16'h0000 && s_q.ovf_flag)
        else $error("rollover did not clear count and set flag");

    sync_delay_a: assert property (sync_path_s ##0 two_stage_s |-> inc)
        else $error("synchronized tick not two cycles late");

    psc_div_a: assert property (on_w && raw_tick && s_q.psc != psc_lim
        && !cnt_wr |=> s_q.psc == $past(s_q.psc) + 3'h1)
        else $error("prescaler failed to advance");

    quarter_a: assert property (on_w && !cs_w && s_q.ctrl[CTRL_PS +: 2] == 2'h0
        && s_q.qdiv == QDIV_LAST |-> inc)
        else $error("timer mode missed its quarter-rate increment");

    osc_drive_a: assert property (s_q.ctrl[CTRL_OSC]
        |-> osc_output_pin_oe && osc_output_pin == !osc_input_pin)
        else $error("oscillator not driven while enabled");

endmodule : sbt_timer

`default_nettype wire

// file: sbt_clk_src.sv
/*
 * Far-side model: external count clock and low-power watch crystal.
 * Assumes the bench calls pulses() right after a sys_clk edge.
 */
`timescale 1ns/10ps
`default_nettype none
module sbt_clk_src (
    input wire logic sys_clk,   // bench clock
    input wire logic sel_osc,   // bursts go to the crystal pin
    output logic ext_clk_pin,   // external count input
    output logic osc_input_pin  // crystal oscillator input
);
    // both pins rest low, so no stray edge arms the counter
    initial begin
        ext_clk_pin = 1'b0;
        osc_input_pin = 1'b0;
    end
    // source runs only when software asks for it
    task automatic pulses(input int n, input int h);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (h) @(posedge sys_clk);
            osc_input_pin <= sel_osc ? ~osc_input_pin : osc_input_pin;
            ext_clk_pin <= sel_osc ? ext_clk_pin : ~ext_clk_pin;
        end
    endtask : pulses
endmodule : sbt_clk_src
`default_nettype wire

// file: sbt_timer_test.sv
/*
 * Self-checking bench for the sixteen-bit timer with an integer count model.
 * Assumes the clock source model and the package of the design.
 */
`timescale 1ns/10ps
`default_nettype none
module sbt_timer_test
    import sbt_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, other_rst = 1'b0, read = 1'b0, write = 1'b0;
    logic adc_enabled = 1'b0, sel_osc = 1'b0, waitrequest, ext_clk_pin, osc_input_pin;
    logic osc_output_pin, osc_output_pin_oe, adc_start, overflow_irq;
    logic [4:0] address = 5'h00;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata;
    logic [7:0] rv;
    int fails = 0, check_count = 0, seed = 5761, adc_n = 0, adc_exp = 0, k;
    int m_cnt, m_psc, m_div, m_cmp = 0, m_trig = 0, m_flag = 0, m_armed;

    // 40 MHz clock; starts counted mid-cycle, clear of the edge
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (adc_start === 1'b1) adc_n++;

    sbt_timer u_sbt_timer (.sys_clk, .rst, .other_rst, .address, .byteenable, .read,
        .write, .writedata, .readdata, .waitrequest, .ext_clk_pin, .osc_input_pin,
        .osc_output_pin, .osc_output_pin_oe, .adc_enabled, .adc_start, .overflow_irq);
    sbt_clk_src u_sbt_clk_src (.sys_clk, .sel_osc, .ext_clk_pin, .osc_input_pin);

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        // waitrequest judged at the rising edge; data taken at that same edge
        @(posedge sys_clk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 20)
            check("bus answer", 16'h1, 16'h0);
        if (n >= 20)
            conclude();
        rv = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    // counter stopped before its bytes are written
    task automatic cfg(input logic [7:0] c, input logic [15:0] v);
        bus(1'b1, OFS_CTRL, 8'h00);
        bus(1'b1, OFS_CNT_LO, v[7:0]);
        bus(1'b1, OFS_CNT_HI, v[15:8]);
        bus(1'b1, OFS_CTRL, c);
        m_cnt = v;
        m_psc = 0;
        m_armed = 0;
        m_div = 1 << c[5:4];
        sel_osc <= c[3];
    endtask : cfg

    // first pulse after enabling only arms the edge detector
    task automatic burst(input int n, input int h);
        u_sbt_clk_src.pulses(n, h);
        repeat (4) @(posedge sys_clk);
        for (int i = 1 - m_armed; i < n; i++) begin
            m_psc = (m_psc + 1) % m_div;
            if (m_psc == 0 && m_trig != 0 && m_cnt == m_cmp)
                adc_exp++;
            if (m_psc == 0 && m_trig != 0 && m_cnt == m_cmp)
                m_cnt = -1;
            if (m_psc == 0 && m_cnt == 65535)
                m_flag = 1;
            if (m_psc == 0)
                m_cnt = (m_cnt + 1) % 65536;
        end
        m_armed = 1;
    endtask : burst

    // high byte read again around the low byte
    task automatic rcnt(input string what);
        logic [7:0] h1;
        bus(1'b0, OFS_CNT_HI, 8'h00);
        h1 = rv;
        bus(1'b0, OFS_CNT_LO, 8'h00);
        check(what, {h1, rv}, 16'(m_cnt));
        bus(1'b0, OFS_CNT_HI, 8'h00);
        check("high byte reread", {8'h00, rv}, {8'h00, h1});
    endtask : rcnt

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, OFS_CTRL, 8'h00);
        check("ctrl at reset", {8'h00, rv}, 16'h0000);
        for (int c = 0; c < 16; c++) begin
            cfg({2'b00, c[1:0], c[3:2], 2'b11}, 16'($random(seed) & 255));
            k = 1 + ($random(seed) & 3);
            burst(1 + m_div * k, 2 + 2 * c[0]);
            rcnt("count per mode");
            check("osc drive", {15'h0, osc_output_pin_oe}, 16'(c[3]));
        end
        $display("test modes done");
        // system clock over four; slack for bus and divider phase
        cfg(8'h01, 16'h0000);
        repeat (400) @(posedge sys_clk);
        bus(1'b1, OFS_CTRL, 8'h00);
        bus(1'b0, OFS_CNT_LO, 8'h00);
        check("timer count", 16'(rv >= 8'h63 && rv <= 8'h66), 16'h1);
        cfg(8'h32, 16'hA5C3);
        other_rst <= 1'b1;
        @(posedge sys_clk);
        other_rst <= 1'b0;
        bus(1'b0, OFS_CTRL, 8'h00);
        check("ctrl kept", {8'h00, rv}, 16'h0032);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, OFS_CTRL, 8'h00);
        check("ctrl cleared", {8'h00, rv}, 16'h0000);
        rcnt("count over resets");
        $display("test resets done");
        cfg(8'h23, 16'h0010);
        burst(3, 2);
        bus(1'b1, OFS_CNT_LO, 8'h10);
        m_psc = 0;
        burst(2, 2);
        rcnt("prescaler cleared");
        $display("test prescaler done");
        bus(1'b1, OFS_IE, 8'h01);
        cfg(8'h0F, 16'hFFFE);
        burst(3, 3);
        rcnt("rollover");
        check("irq set", {15'h0, overflow_irq}, 16'(m_flag));
        bus(1'b1, OFS_CNT_HI, 8'h80);
        bus(1'b1, OFS_FLAG, 8'h00);
        m_cnt = m_cnt | 32'h8000;
        m_flag = 0;
        burst(3, 3);
        rcnt("preloaded tick");
        check("irq cleared", {15'h0, overflow_irq}, 16'(m_flag));
        $display("test clock tick done");
        bus(1'b1, OFS_CMP_LO, 8'h05);
        bus(1'b1, OFS_CMP_HI, 8'h00);
        bus(1'b1, OFS_CMODE, {4'h0, CMODE_TRIG});
        adc_enabled <= 1'b1;
        m_cmp = 5;
        m_trig = 1;
        cfg(8'h03, 16'h0000);
        burst(14, 2);
        rcnt("period clear");
        check("conversions", 16'(adc_n), 16'(adc_exp));
        $display("test trigger done");
        // writes stepping across trigger edges keep their value
        m_cmp = 0;
        bus(1'b1, OFS_CMP_LO, 8'h00);
        cfg(8'h01, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFS_CNT_LO, 8'h00);
        end
        bus(1'b1, OFS_CTRL, 8'h00);
        rcnt("write over trigger");
        $display("test write priority done");
        conclude();
    end
endmodule : sbt_timer_test
`default_nettype wire
